// ---- design/slc_pkg.sv ----
package slc_pkg;
  // Element counts and data widths.
  localparam int SLC_NUM = 8;
  localparam int SLC_W = 16;
  // Dimming sweep limits, in percent.
  localparam logic [15:0] SLC_DIM_MIN = 16'h0005;
  localparam logic [15:0] SLC_DIM_MAX = 16'h0064;
  // Reset values of stored state.
  localparam logic [15:0] SLC_VAL_RST = 16'h0000;
  localparam logic [15:0] SLC_CNT_RST = 16'h0000;
  localparam logic [16:0] SLC_ONE = 17'h00001;

  // Counter modes.
  typedef enum logic [2:0] {
    CM_HIGH, CM_LOW, CM_RISE, CM_FALL, CM_ANY, CM_DIM
  } slc_cmode_type;

  // Delay timer modes.
  typedef enum logic [1:0] {TM_NONE, TM_RISE, TM_FALL} slc_tmode_type;

  // Flasher phases.
  typedef enum logic [1:0] {FL_IDLE, FL_HIGH, FL_LOW, FL_DONE} slc_fstate_type;

  // Counter input signals.
  typedef struct packed {
    logic inc;
    logic dec;
    logic rst;
  } slc_cin_type;

  // Counter configuration; all times are in ticks.
  typedef struct packed {
    slc_cmode_type mode;
    logic [15:0] pressStep;
    logic [15:0] repeatStep;
    logic [15:0] floorValue;
    logic [15:0] ceilingValue;
    logic [15:0] onLevel;
    logic [15:0] longPress;
    logic [15:0] repeatInterval;
  } slc_ccfg_type;

  // Counter state.
  typedef struct packed {
    logic [15:0] val;
    logic [15:0] hold;
    logic held;
    logic prevInc;
    logic prevDec;
    logic incOwn;
    logic decOwn;
    logic power;
    logic dirUp;
    logic over;
  } slc_cst_type;

  // Flasher configuration; times in ticks, count zero means no limit.
  typedef struct packed {
    logic [15:0] highTime;
    logic [15:0] lowTime;
    logic [15:0] blinkCount;
  } slc_fcfg_type;
endpackage

// ---- design/slc_timer.sv ----
`timescale 1ns/1ps
module slc_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic sigIn,
  input wire slc_pkg::slc_tmode_type mode,
  input wire logic [15:0] lagTime,
  output logic sigOut
);
  import slc_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic out;
  } slc_tst_type;

  slc_tst_type state_ff;
  slc_tst_type nxt_state;
  logic lagTo;

  // Only the edge toward the lagged level waits; the other passes at once.
  always_comb begin
    nxt_state = state_ff;
    lagTo = (mode == TM_RISE);
    if (tick) begin
      case (mode)
        TM_RISE, TM_FALL: begin
          if (sigIn == state_ff.out) begin
            nxt_state.cnt = SLC_CNT_RST;
          end else if (sigIn != lagTo) begin
            nxt_state.out = sigIn;
            nxt_state.cnt = SLC_CNT_RST;
          end else if ({1'b0, state_ff.cnt} + SLC_ONE >= {1'b0, lagTime}) begin
            nxt_state.out = sigIn;
            nxt_state.cnt = SLC_CNT_RST;
          end else begin
            nxt_state.cnt = state_ff.cnt + 16'h0001;
          end
        end
        default: begin
          nxt_state.out = sigIn;
          nxt_state.cnt = SLC_CNT_RST;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sigOut = state_ff.out;

  a_tmr_copy_input: assert property (@(posedge clk) disable iff (!nrst)
    (tick && mode == TM_NONE) |=> sigOut == $past(sigIn))
    else $error("Timer in no-delay mode did not copy its input.");

  a_tmr_rise_cause: assert property (@(posedge clk) disable iff (!nrst)
    ($rose(sigOut) && $past(mode) == TM_RISE && $past(lagTime) > 16'h0001)
    |-> $past(sigIn, 2))
    else $error("Rise-lag timer rose without a lasting input.");
endmodule

// ---- design/slc_flash.sv ----
`timescale 1ns/1ps
module slc_flash (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic sigIn,
  input wire slc_pkg::slc_fcfg_type cfg,
  output logic sigOut
);
  import slc_pkg::*;

  typedef struct packed {
    slc_fstate_type fst;
    logic [15:0] cnt;
    logic [15:0] cyc;
    logic prevIn;
    logic out;
  } slc_fst_type;

  slc_fst_type state_ff;
  slc_fst_type nxt_state;

  // A new burst needs a fresh rising edge, so a finished burst stays dark.
  always_comb begin
    nxt_state = state_ff;
    if (tick) begin
      nxt_state.prevIn = sigIn;
      if (!sigIn) begin
        nxt_state.fst = FL_IDLE;
      end else begin
        case (state_ff.fst)
          FL_IDLE: begin
            if (!state_ff.prevIn) begin
              nxt_state.fst = FL_HIGH;
              nxt_state.cnt = SLC_CNT_RST;
              nxt_state.cyc = SLC_CNT_RST;
            end
          end
          FL_HIGH: begin
            if ({1'b0, state_ff.cnt} + SLC_ONE >= {1'b0, cfg.highTime}) begin
              nxt_state.fst = FL_LOW;
              nxt_state.cnt = SLC_CNT_RST;
            end else begin
              nxt_state.cnt = state_ff.cnt + 16'h0001;
            end
          end
          FL_LOW: begin
            if ({1'b0, state_ff.cnt} + SLC_ONE >= {1'b0, cfg.lowTime}) begin
              nxt_state.cnt = SLC_CNT_RST;
              if (cfg.blinkCount != SLC_CNT_RST &&
                  {1'b0, state_ff.cyc} + SLC_ONE >= {1'b0, cfg.blinkCount}) begin
                nxt_state.fst = FL_DONE;
              end else begin
                nxt_state.fst = FL_HIGH;
                nxt_state.cyc = state_ff.cyc + 16'h0001;
              end
            end else begin
              nxt_state.cnt = state_ff.cnt + 16'h0001;
            end
          end
          FL_DONE: begin
            nxt_state.fst = FL_DONE;
          end
          default: begin
            nxt_state.fst = FL_IDLE;
          end
        endcase
      end
    end
    nxt_state.out = (nxt_state.fst == FL_HIGH);
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sigOut = state_ff.out;

  a_fl_input_low: assert property (@(posedge clk) disable iff (!nrst)
    (tick && !sigIn) |=> !sigOut)
    else $error("Flasher output high after its input dropped.");

  a_fl_done_dark: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff.fst == FL_DONE) |-> (!sigOut && $stable(sigOut)))
    else $error("Flasher output moved after its burst ended.");
endmodule

// ---- design/slc_top.sv ----
// Behaviour
// - Eight counters, each set to one of six modes.
// - Level modes count while the input sits at its active level.
// - Edge modes step by the repeat amount per selected edge.
// - A fresh press steps the counter by the press amount.
// - Held input steps by repeat amount after long press, then each interval.
// - The reset input loads the floor value.
// - Outside dimming mode the value never rises above the ceiling; increments saturate there.
// - Over-limit output is high when value is at or above on-level; in dimming mode it shows power.
// - In level modes a press during the other input's press is ignored.
// - Dimming mode ignores decrement; short press toggles power output.
// - Long press sweeps level 5 to 100 and back; level is kept.
// - Eight delay timers with lag up to 65535 ticks.
// - Rise lag delays rising edge, fall lag falling edge, else copy.
// - Rise-lag pulses or fall-lag gaps shorter than the lag do not reach the output.
// - Eight flashers drive high then low for set times while enabled.
// - A flasher stops after its cycle count or when input drops.
// - Eight latches: set drives high, reset low, neither holds.
`timescale 1ns/1ps
module slc_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire slc_pkg::slc_cin_type [slc_pkg::SLC_NUM-1:0] cntIn,
  input wire slc_pkg::slc_ccfg_type [slc_pkg::SLC_NUM-1:0] cntCfg,
  input wire logic [slc_pkg::SLC_NUM-1:0] timerIn,
  input wire slc_pkg::slc_tmode_type [slc_pkg::SLC_NUM-1:0] timerMode,
  input wire logic [slc_pkg::SLC_NUM-1:0][15:0] lagTime,
  input wire logic [slc_pkg::SLC_NUM-1:0] flashIn,
  input wire slc_pkg::slc_fcfg_type [slc_pkg::SLC_NUM-1:0] flashCfg,
  input wire logic [slc_pkg::SLC_NUM-1:0] latchSet,
  input wire logic [slc_pkg::SLC_NUM-1:0] latchRst,
  output logic [slc_pkg::SLC_NUM-1:0] countOverLimit,
  output logic [slc_pkg::SLC_NUM-1:0][15:0] countValue,
  output logic [slc_pkg::SLC_NUM-1:0] timerOut,
  output logic [slc_pkg::SLC_NUM-1:0] flashOut,
  output logic [slc_pkg::SLC_NUM-1:0] latchOut
);
  import slc_pkg::*;

  typedef struct packed {
    slc_cst_type [SLC_NUM-1:0] cnt;
    logic [SLC_NUM-1:0] latch;
  } slc_top_type;

  slc_top_type state_ff;
  slc_top_type nxt_state;

  // Adds with saturation; a value already above the ceiling is pulled down.
  function automatic logic [15:0] sat_up(
    input logic [15:0] v,
    input logic [15:0] amt,
    input logic [15:0] lim
  );
    logic [16:0] sum;
    sum = {1'b0, v} + {1'b0, amt};
    if (sum > {1'b0, lim}) begin
      return lim;
    end
    return sum[15:0];
  endfunction

  // Subtracts with saturation at the lower bound.
  function automatic logic [15:0] sat_dn(
    input logic [15:0] v,
    input logic [15:0] amt,
    input logic [15:0] lim
  );
    if ({1'b0, v} < {1'b0, lim} + {1'b0, amt}) begin
      return lim;
    end
    return v - amt;
  endfunction

  // One step of a counter in the chosen direction between floor and ceiling.
  function automatic logic [15:0] cnt_move(
    input logic [15:0] v,
    input logic [15:0] amt,
    input logic up,
    input slc_ccfg_type c
  );
    if (up) begin
      return sat_up(v, amt, c.ceilingValue);
    end
    return sat_dn(v, amt, c.floorValue);
  endfunction

  // Hold timer expiry: first the long press, then each repeat interval.
  function automatic logic hold_hit(
    input slc_cst_type s,
    input slc_ccfg_type c
  );
    logic [16:0] h;
    h = {1'b0, s.hold} + SLC_ONE;
    if (s.held) begin
      return h >= {1'b0, c.repeatInterval};
    end
    return h >= {1'b0, c.longPress};
  endfunction

  // Edge detector for the three edge modes.
  function automatic logic edge_of(
    input slc_cmode_type m,
    input logic prev,
    input logic cur
  );
    case (m)
      CM_RISE: return cur & ~prev;
      CM_FALL: return ~cur & prev;
      default: return cur ^ prev;
    endcase
  endfunction

  // Advances one counter by one tick. Holding the previous raw inputs
  // rather than active levels keeps a mode change from faking an edge
  // in the edge modes; a dimming-mode release may still appear on a switch.
  function automatic slc_cst_type cnt_step(
    input slc_cst_type s,
    input slc_ccfg_type c,
    input slc_cin_type i
  );
    slc_cst_type n;
    logic lowAct;
    logic aInc;
    logic aDec;
    logic apInc;
    logic apDec;
    logic pInc;
    logic pDec;
    logic hit;
    logic [15:0] v;
    n = s;
    lowAct = (c.mode == CM_LOW);
    aInc = i.inc ^ lowAct;
    aDec = i.dec ^ lowAct;
    apInc = s.prevInc ^ lowAct;
    apDec = s.prevDec ^ lowAct;
    pInc = 1'b0;
    pDec = 1'b0;
    hit = hold_hit(s, c);
    v = s.val;
    case (c.mode)
      CM_HIGH, CM_LOW: begin
        // A press counts only while the other input owns nothing.
        pInc = aInc & ~apInc & ~s.decOwn;
        pDec = aDec & ~apDec & ~s.incOwn & ~pInc;
        n.incOwn = aInc & (s.incOwn | pInc);
        n.decOwn = aDec & (s.decOwn | pDec);
        if (pInc | pDec) begin
          n.hold = SLC_CNT_RST;
          n.held = 1'b0;
          n.val = cnt_move(v, c.pressStep, pInc, c);
        end else if (n.incOwn | n.decOwn) begin
          if (hit) begin
            n.hold = SLC_CNT_RST;
            n.held = 1'b1;
            n.val = cnt_move(v, c.repeatStep, n.incOwn, c);
          end else begin
            n.hold = s.hold + 16'h0001;
          end
        end else begin
          n.hold = SLC_CNT_RST;
          n.held = 1'b0;
        end
      end
      CM_RISE, CM_FALL, CM_ANY: begin
        // Coincident edges on both inputs favour the increment.
        n.incOwn = 1'b0;
        n.decOwn = 1'b0;
        if (edge_of(c.mode, s.prevInc, i.inc)) begin
          n.val = cnt_move(v, c.repeatStep, 1'b1, c);
        end else if (edge_of(c.mode, s.prevDec, i.dec)) begin
          n.val = cnt_move(v, c.repeatStep, 1'b0, c);
        end
      end
      CM_DIM: begin
        // Only the increment input is looked at here.
        n.incOwn = 1'b0;
        n.decOwn = 1'b0;
        if (i.inc & ~s.prevInc) begin
          n.hold = SLC_CNT_RST;
          n.held = 1'b0;
        end else if (i.inc) begin
          if (hit) begin
            n.hold = SLC_CNT_RST;
            n.held = 1'b1;
            if (s.dirUp) begin
              n.val = sat_up(v, c.repeatStep, SLC_DIM_MAX);
              n.dirUp = (n.val != SLC_DIM_MAX);
            end else begin
              n.val = sat_dn(v, c.repeatStep, SLC_DIM_MIN);
              n.dirUp = (n.val == SLC_DIM_MIN);
            end
          end else begin
            n.hold = s.hold + 16'h0001;
          end
        end else if (s.prevInc) begin
          // Release: a short press flips power and leaves the level alone.
          if (!s.held) begin
            n.power = ~s.power;
          end
          n.hold = SLC_CNT_RST;
          n.held = 1'b0;
        end
      end
      default: begin
        n.incOwn = 1'b0;
        n.decOwn = 1'b0;
      end
    endcase
    n.prevInc = i.inc;
    n.prevDec = i.dec;
    if (i.rst) begin
      n.val = c.floorValue;
    end
    return n;
  endfunction

  // Counters and latches advance on the tick; the limit flag follows the
  // value every clock so a config change shows without waiting for a tick.
  always_comb begin
    nxt_state = state_ff;
    for (int k = 0; k < SLC_NUM; k++) begin
      if (tick) begin
        nxt_state.cnt[k] = cnt_step(state_ff.cnt[k], cntCfg[k], cntIn[k]);
        if (latchRst[k]) begin
          nxt_state.latch[k] = 1'b0;
        end else if (latchSet[k]) begin
          nxt_state.latch[k] = 1'b1;
        end
      end
      if (cntCfg[k].mode == CM_DIM) begin
        nxt_state.cnt[k].over = nxt_state.cnt[k].power;
      end else begin
        nxt_state.cnt[k].over = (nxt_state.cnt[k].val >= cntCfg[k].onLevel);
      end
    end
  end

  // State register; every counter value restarts at zero.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs come straight from the state register.
  always_comb begin
    for (int k = 0; k < SLC_NUM; k++) begin
      countOverLimit[k] = state_ff.cnt[k].over;
      countValue[k] = state_ff.cnt[k].val;
    end
  end
  assign latchOut = state_ff.latch;

  // Timers and flashers, one instance per element, each with its own state.
  generate
    for (genvar g = 0; g < SLC_NUM; g++) begin : gen_elem
      slc_timer u_timer (
        .clk(clk),
        .nrst(nrst),
        .tick(tick),
        .sigIn(timerIn[g]),
        .mode(timerMode[g]),
        .lagTime(lagTime[g]),
        .sigOut(timerOut[g])
      );

      slc_flash u_flash (
        .clk(clk),
        .nrst(nrst),
        .tick(tick),
        .sigIn(flashIn[g]),
        .cfg(flashCfg[g]),
        .sigOut(flashOut[g])
      );

      a_cnt_reset_floor: assert property (@(posedge clk) disable iff (!nrst)
        (tick && cntIn[g].rst) |=> countValue[g] == $past(cntCfg[g].floorValue))
        else $error("Counter reset did not load the floor value.");

      a_cnt_ceiling_cap: assert property (@(posedge clk) disable iff (!nrst)
        (tick && !cntIn[g].rst && cntCfg[g].mode != CM_DIM &&
         countValue[g] <= cntCfg[g].ceilingValue)
        |=> countValue[g] <= $past(cntCfg[g].ceilingValue))
        else $error("Counter climbed above its ceiling.");

      a_cnt_over_level: assert property (@(posedge clk) disable iff (!nrst)
        (!tick && cntCfg[g].mode != CM_DIM)
        |=> countOverLimit[g] == $past(countValue[g] >= cntCfg[g].onLevel))
        else $error("Over-limit flag disagrees with counter value.");

      a_cnt_edge_step: assert property (@(posedge clk) disable iff (!nrst)
        (tick && cntCfg[g].mode == CM_RISE && cntIn[g].inc &&
         !state_ff.cnt[g].prevInc && !cntIn[g].rst &&
         {1'b0, countValue[g]} + {1'b0, cntCfg[g].repeatStep} <=
         {1'b0, cntCfg[g].ceilingValue})
        |=> countValue[g] == $past(countValue[g]) + $past(cntCfg[g].repeatStep))
        else $error("Rising edge did not step the counter.");

      a_dim_dec_ignored: assert property (@(posedge clk) disable iff (!nrst)
        (tick && cntCfg[g].mode == CM_DIM && !cntIn[g].inc &&
         !state_ff.cnt[g].prevInc && !cntIn[g].rst)
        |=> $stable(countValue[g]))
        else $error("Dimming counter moved without its button.");

      a_latch_reset_wins: assert property (@(posedge clk) disable iff (!nrst)
        (tick && latchRst[g]) |=> !latchOut[g])
        else $error("Latch not low after reset input.");

      a_latch_set_high: assert property (@(posedge clk) disable iff (!nrst)
        (tick && latchSet[g] && !latchRst[g]) |=> latchOut[g])
        else $error("Latch not high after set input.");

      a_latch_tick_hold: assert property (@(posedge clk) disable iff (!nrst)
        !tick |=> $stable(latchOut[g]))
        else $error("Latch changed without a tick.");
    end
  endgenerate
endmodule

// ---- bench/slc_partner.sv ----
`timescale 1ns/1ps
// Stands in for the input monitors' sampling: one tick pulse after gap idle cycles.
module slc_partner (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] gap,
  output logic tick
);
  logic [3:0] waitFf;

  // Quiet during reset so no element steps before the first tick is allowed.
  initial begin
    tick = 1'b0;
    waitFf = 4'h0;
  end

  // A gap of zero gives a tick every cycle, the fastest the elements must take.
  always @(posedge clk) begin
    if (!nrst || waitFf != 4'h0) begin
      tick <= #1 1'b0;
      waitFf <= nrst ? waitFf - 4'h1 : 4'h0;
    end else begin
      tick <= #1 1'b1;
      waitFf <= gap;
    end
  end
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import slc_pkg::*;
  logic clk, nrst, tick;
  logic [3:0] gap;
  slc_cin_type [SLC_NUM-1:0] cntIn;
  slc_ccfg_type [SLC_NUM-1:0] cntCfg;
  logic [SLC_NUM-1:0] timerIn, flashIn, latchSet, latchRst;
  slc_tmode_type [SLC_NUM-1:0] timerMode;
  logic [SLC_NUM-1:0][15:0] lagTime;
  slc_fcfg_type [SLC_NUM-1:0] flashCfg;
  logic [SLC_NUM-1:0] countOverLimit, timerOut, flashOut, latchOut;
  logic [SLC_NUM-1:0][15:0] countValue;
  logic [SLC_NUM-1:0] eL, eT, eF, prevF;
  int num_errors, n_compared, v, lo, hi;
  int tCnt[SLC_NUM], fT[SLC_NUM], fN[SLC_NUM], fPh[SLC_NUM];
  logic [31:0] lfsr;
  logic [15:0] last;
  logic act;
  slc_cmode_type em[3] = '{CM_RISE, CM_FALL, CM_ANY};

  slc_partner PTR (.clk, .nrst, .gap, .tick);
  slc_top DUT (.clk, .nrst, .tick, .cntIn, .cntCfg, .timerIn, .timerMode, .lagTime,
    .flashIn, .flashCfg, .latchSet, .latchRst, .countOverLimit, .countValue, .timerOut,
    .flashOut, .latchOut);

  function automatic logic [31:0] nxt(input logic [31:0] l);
    return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Waits for the next tick edge; idle edges in between must leave latch and timer outputs alone.
  task automatic tk();
    logic [15:0] held;
    held = {latchOut, timerOut};
    forever begin
      @(posedge clk);
      if (tick) break;
      #1;
      chk({latchOut, timerOut}, held, "idle edge moved output");
    end
    #1;
  endtask

  // Reference for latches, timers and flashers, run once per tick.
  task automatic model();
    for (int i = 0; i < SLC_NUM; i++) begin
      eL[i] = latchRst[i] ? 1'b0 : (latchSet[i] ? 1'b1 : eL[i]);
      act = (timerMode[i] == TM_RISE) ? timerIn[i] : !timerIn[i];
      if (timerMode[i] == TM_NONE || !act) begin
        tCnt[i] = 0;
        eT[i] = timerIn[i];
      end else begin
        tCnt[i]++;
        if (tCnt[i] >= int'(lagTime[i])) eT[i] = timerIn[i];
      end
      if (!flashIn[i]) fPh[i] = 0;
      else if (!prevF[i]) begin
        fPh[i] = 1;
        fT[i] = 1;
        fN[i] = 0;
      end else if (fPh[i] == 1) begin
        if (fT[i] < int'(flashCfg[i].highTime)) fT[i]++;
        else begin
          fPh[i] = 2;
          fT[i] = 1;
        end
      end else if (fPh[i] == 2) begin
        if (fT[i] < int'(flashCfg[i].lowTime)) fT[i]++;
        else begin
          fN[i]++;
          fT[i] = 1;
          fPh[i] = (flashCfg[i].blinkCount != 0 && fN[i] >= flashCfg[i].blinkCount) ? 3 : 1;
        end
      end
      eF[i] = (fPh[i] == 1);
      prevF[i] = flashIn[i];
    end
  endtask

  // Clock generation.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard, far beyond the under a thousand cycles the sequence needs.
  initial begin
    #500000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end

  // Main sequence: directed counter cases, then random traffic on the other elements.
  initial begin
    nrst = 1'b0;
    gap = 4'h0;
    lfsr = 32'h7C3F;
    cntIn = '0;
    cntCfg = '0;
    {timerIn, flashIn, latchSet, latchRst, eL, eT, eF, prevF} = '0;
    for (int i = 0; i < SLC_NUM; i++) begin
      timerMode[i] = slc_tmode_type'(i % 3);
      lagTime[i] = 16'(1 + i / 2);
      flashCfg[i] = '{highTime: 16'(1 + i % 3), lowTime: 16'(1 + i % 2),
        blinkCount: 16'(i % 3)};
      tCnt[i] = 0;
      fPh[i] = 0;
    end
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    cntCfg[0] = '{mode: CM_RISE, pressStep: 16'h0002, repeatStep: 16'h0003,
      floorValue: 16'h000A, ceilingValue: 16'h0010, onLevel: 16'h000D,
      longPress: 16'h0003, repeatInterval: 16'h0002};
    foreach (em[k]) begin
      cntCfg[0].mode = em[k];
      cntIn[0] = '{inc: 1'b0, dec: 1'b0, rst: 1'b1};
      tk();
      chk(countValue[0], 16'h000A, "floor load");
      cntIn[0].rst = 1'b0;
      tk();
      v = 10;
      for (int j = 0; j < 4; j++) begin
        cntIn[0].inc = ~j[0];
        tk();
        if ((em[k] == CM_RISE && !j[0]) || (em[k] == CM_FALL && j[0]) || em[k] == CM_ANY)
          v = (v + 3 > 16) ? 16 : v + 3;
        chk(countValue[0], v[15:0], "edge step");
        chk(countOverLimit[0], 16'(v >= 13), "over limit");
      end
    end
    gap = 4'h1;
    cntCfg[0].repeatStep = 16'h0001;
    cntCfg[0].ceilingValue = 16'h0064;
    for (int m = 0; m < 2; m++) begin
      act = (m == 0);
      cntCfg[0].mode = act ? CM_HIGH : CM_LOW;
      cntIn[0] = '{inc: ~act, dec: ~act, rst: 1'b1};
      tk();
      cntIn[0].rst = 1'b0;
      tk();
      cntIn[0].inc = act;
      tk();
      chk(countValue[0], 16'h000C, "press step");
      cntIn[0].dec = act;
      for (int j = 1; j < 8; j++) begin
        tk();
        chk(countValue[0], 16'(12 + (j - 1) / 2), "held repeat");
      end
      cntIn[0] = '{inc: ~act, dec: ~act, rst: 1'b0};
      tk();
      chk(countValue[0], 16'h000F, "release");
    end
    // Drop both buttons before the mode switch, or the dimming counter sees a release.
    cntIn[0] = '0;
    tk();
    chk(countValue[0], 16'h0011, "low press wins");
    cntCfg[0] = '{mode: CM_DIM, pressStep: 16'h0001, repeatStep: 16'h0014,
      floorValue: 16'h0032, ceilingValue: 16'h0064, onLevel: 16'h0000,
      longPress: 16'h0002, repeatInterval: 16'h0001};
    cntIn[0] = '{inc: 1'b0, dec: 1'b0, rst: 1'b1};
    tk();
    cntIn[0].rst = 1'b0;
    tk();
    chk({countOverLimit[0], countValue[0][14:0]}, 16'h0032, "dim start");
    cntIn[0].inc = 1'b1;
    tk();
    cntIn[0].inc = 1'b0;
    tk();
    chk(countOverLimit[0], 16'h0001, "short press toggles");
    cntIn[0].dec = 1'b1;
    tk();
    cntIn[0].dec = 1'b0;
    tk();
    chk({countOverLimit[0], countValue[0][14:0]}, 16'h8032, "dec ignored");
    cntIn[0].inc = 1'b1;
    lo = 200;
    hi = 0;
    repeat (16) begin
      tk();
      if (countValue[0] < lo) lo = countValue[0];
      if (countValue[0] > hi) hi = countValue[0];
    end
    chk(16'(lo), SLC_DIM_MIN, "sweep low end");
    chk(16'(hi), SLC_DIM_MAX, "sweep high end");
    cntIn[0].inc = 1'b0;
    tk();
    chk(countOverLimit[0], 16'h0001, "no toggle after sweep");
    last = countValue[0];
    cntIn[0].inc = 1'b1;
    tk();
    cntIn[0].inc = 1'b0;
    tk();
    chk({countOverLimit[0], countValue[0][14:0]}, {1'b0, last[14:0]}, "level kept");
    for (int n = 0; n < 400; n++) begin
      lfsr = nxt(lfsr);
      gap = n[7] ? 4'h2 : 4'h0;
      latchSet = lfsr[7:0];
      latchRst = lfsr[15:8] & lfsr[23:16];
      timerIn = timerIn ^ (lfsr[23:16] & lfsr[31:24]);
      flashIn = flashIn ^ (lfsr[15:8] & lfsr[7:0] & lfsr[31:24]);
      tk();
      model();
      chk(latchOut, eL, "latch");
      chk(timerOut, eT, "timer");
      chk(flashOut, eF, "flasher");
    end
    close_out();
  end
endmodule
